// [hdl/nbc_pkg.sv]
package nbc_pkg;
   // ==========================================================
   // command codes
   // read, id, reset, program, erase, status, read-out, cache and parameter codes
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_READ_GO = 8'h30;
   localparam logic [7:0] CMD_READ_CB = 8'h35;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_PROG = 8'h80;
   localparam logic [7:0] CMD_PROG_GO = 8'h10;
   localparam logic [7:0] CMD_CACHE_GO = 8'h15;
   localparam logic [7:0] CMD_PLANE_GO = 8'h11;
   localparam logic [7:0] CMD_PROG_P2 = 8'h81;
   localparam logic [7:0] CMD_COPY = 8'h85;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] CMD_ERASE_P1 = 8'hd1;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_STATUS_EN = 8'h78;
   localparam logic [7:0] CMD_STATUS_X2 = 8'hf2;
   localparam logic [7:0] CMD_STATUS_X3 = 8'hf3;
   localparam logic [7:0] CMD_RDOUT = 8'h05;
   localparam logic [7:0] CMD_RDOUT_GO = 8'he0;
   localparam logic [7:0] CMD_RCACHE = 8'h31;
   localparam logic [7:0] CMD_RCACHE_END = 8'h3f;
   localparam logic [7:0] CMD_PARAM = 8'hec;
   // ==========================================================
   // address field layout
   localparam int COL8_W = 12;
   localparam int COL16_W = 11;
   localparam int PAGE_W = 6;
   localparam int BLK_W = 12;
   localparam int ADDR_CYCLES = 5;
   // ==========================================================
   // strobe timing
   localparam int CLK_HZ = 20_000_000;
   localparam int T_STROBE_NS = 50;
   localparam int STROBE_CYC = (T_STROBE_NS * (CLK_HZ / 1_000_000)
      + 999) / 1000;
   // ==========================================================
   // cycle kinds
   typedef enum logic [1:0]
   {
      NBC_CYC_CMD = 2'b00,
      NBC_CYC_ADDR = 2'b01,
      NBC_CYC_WR = 2'b11,
      NBC_CYC_RD = 2'b10
   } nbc_cyc_type;

   function automatic logic nbc_busy_ok(input logic [7:0] c);
      return c == CMD_RESET || c == CMD_STATUS || c == CMD_STATUS_EN
         || c == CMD_STATUS_X2 || c == CMD_STATUS_X3;
   endfunction : nbc_busy_ok

   function automatic logic nbc_modify(input logic [7:0] c);
      return c == CMD_PROG || c == CMD_PROG_P2 || c == CMD_COPY
         || c == CMD_ERASE || c == CMD_PROG_GO || c == CMD_CACHE_GO
         || c == CMD_PLANE_GO || c == CMD_ERASE_GO
         || c == CMD_ERASE_P1;
   endfunction : nbc_modify
endpackage : nbc_pkg

// [hdl/nbc_cyc_if.sv]
`timescale 1ns/1ps
interface nbc_cyc_if;
   import nbc_pkg::*;
   logic req;
   nbc_cyc_type kind;
   logic [15:0] wdata;
   logic ack;
   logic [15:0] rdata;
   modport master (output req, output kind, output wdata,
      input ack, input rdata);
   modport slave (input req, input kind, input wdata,
      output ack, output rdata);
endinterface : nbc_cyc_if

// [hdl/nbc_addr_pack.sv]
`timescale 1ns/1ps
module nbc_addr_pack
   import nbc_pkg::*;
(
   input wire logic x16,
   input wire logic [COL8_W-1:0] col,
   input wire logic [PAGE_W-1:0] page,
   input wire logic plane,
   input wire logic [BLK_W-1:0] blk,
   input wire logic die,
   output logic [39:0] bytes
);
   logic [30:0] a8;
   logic [29:0] a16;
   logic [7:0] b1;
   logic [7:0] b2;
   logic [7:0] b3;
   logic [7:0] b4;
   logic [7:0] b5;
   assign a8 = {die, blk[11:1], blk[0] | plane, page, col};
   assign a16 = {die, blk[11:1], blk[0] | plane, page, col[10:0]};
   assign b1 = x16 ? a16[7:0] : a8[7:0];
   assign b2 = x16 ? {5'h0, a16[10:8]} : {4'h0, a8[11:8]};
   assign b3 = x16 ? a16[18:11] : a8[19:12];
   assign b4 = x16 ? a16[26:19] : a8[27:20];
   assign b5 = x16 ? {5'h0, a16[29:27]} : {5'h0, a8[30:28]};
   assign bytes = {b5, b4, b3, b2, b1};
endmodule : nbc_addr_pack

// [hdl/nbc_bus_phy.sv]
`timescale 1ns/1ps
module nbc_bus_phy
   import nbc_pkg::*;
#(
   parameter int HOLD = STROBE_CYC
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   nbc_cyc_if.slave cyc,
   output logic cle,
   output logic ale,
   output logic ce_n,
   output logic we_n,
   output logic read_strobe_n,
   output logic [15:0] io_out,
   output logic io_oe,
   input wire logic [15:0] io_in
);
   logic [7:0] cnt;
   logic [1:0] ph;
   logic busy;
   logic tick;
   // ==========================================================
   // strobe sequencing
   assign tick = cnt == 8'(HOLD - 1);
   assign cyc.ack = busy && ph == 2'd2 && tick;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy <= 1'b0;
         ph <= 2'd0;
         cnt <= 8'h00;
      end
      else if (!busy)
      begin
         busy <= cyc.req;
         ph <= 2'd0;
         cnt <= 8'h00;
      end
      else if (tick)
      begin
         cnt <= 8'h00;
         ph <= 2'(ph + 2'd1);
         if (ph == 2'd2)
            busy <= 1'b0;
      end
      else
         cnt <= 8'(cnt + 8'd1);
   end
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cle <= 1'b0;
         ale <= 1'b0;
         ce_n <= 1'b1;
         we_n <= 1'b1;
         read_strobe_n <= 1'b1;
         io_out <= 16'h0000;
         io_oe <= 1'b0;
      end
      else
      begin
         ce_n <= !busy;
         cle <= busy && cyc.kind == NBC_CYC_CMD;
         ale <= busy && cyc.kind == NBC_CYC_ADDR;
         io_oe <= busy && cyc.kind != NBC_CYC_RD;
         // upper lines zero for cmd and addr
         io_out <= cyc.kind == NBC_CYC_WR ? cyc.wdata
            : {8'h00, cyc.wdata[7:0]};
         we_n <= !(busy && ph == 2'd1 && cyc.kind != NBC_CYC_RD);
         read_strobe_n <= !(busy && ph == 2'd1
            && cyc.kind == NBC_CYC_RD);
      end
   end
   assign cyc.rdata = io_in;
endmodule : nbc_bus_phy

// [hdl/nbc_host.sv]
// Behaviour
// - x8 host sends five address bytes, LSB first, upper bits zero.
// - x16 five address bytes, second byte three bits, fifth three.
// - read, copy-back read, id, reset and erase codes.
// - program opens 80h, closes 10h, cache 15h, copy-back 85h.
// - two-plane program 80h, data, 11h, 81h or 80h, 10h.
// - two-plane cache program ends 15h or 10h.
// - two-plane copy-back 85h, 11h, 81h or 85h, 10h.
// - two-plane erase legacy 60h 60h D0h or ONFI 60h D1h 60h D0h.
// - read cache, cache end, random in/out and parameter codes.
// - while busy the only commands issued are reset and status reads.
// - command latched on write strobe rise with CLE high.
// - write protect held high for program and erase.
// - command bytes always on the low eight lines.
// - address bytes on low eight lines with ALE high.
// - data words latched one per write strobe rise.
// - data read out by toggling read strobe, CE low.
`timescale 1ns/1ps
module nbc_host
   import nbc_pkg::*;
#(
   parameter int STROBE = STROBE_CYC
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic x16,
   input wire logic onfi,
   input wire logic op_valid,
   output logic op_ready,
   input wire logic [3:0] op_kind,
   input wire logic [7:0] op_cmd,
   input wire logic [COL8_W-1:0] op_col,
   input wire logic [PAGE_W-1:0] op_page,
   input wire logic [BLK_W-1:0] op_blk,
   input wire logic op_plane,
   input wire logic op_die,
   input wire logic [15:0] op_wdata,
   output logic [15:0] op_rdata,
   output logic op_done,
   output logic op_refused,
   output logic cle,
   output logic ale,
   output logic ce_n,
   output logic we_n,
   output logic read_strobe_n,
   output logic wp_n,
   output logic [15:0] io_out,
   output logic io_oe,
   input wire logic [15:0] io_in,
   input wire logic ready_busy_n
);
   import nbc_pkg::*;
   // op kinds: 0 cmd, 1 addr5, 2 write word, 3 read word, 4 addr col
   typedef enum logic [1:0]
   {
      NBC_IDLE = 2'b00,
      NBC_RUN = 2'b01,
      NBC_WAIT = 2'b11
   } nbc_st_type;
   nbc_st_type st;
   nbc_st_type next_st;
   nbc_cyc_if cyc ();
   logic [39:0] abytes;
   logic [39:0] ashift;
   logic [2:0] left;
   logic [3:0] kind;
   logic [7:0] cmd;
   logic [15:0] wdata;
   logic [2:0] rb_sync;
   logic rb_ready;
   logic refuse;
   logic accept;
   logic last;
   // ==========================================================
   // ready busy synchroniser
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rb_sync <= 3'b111;
         rb_ready <= 1'b1;
      end
      else
      begin
         rb_sync <= {rb_sync[1:0], ready_busy_n};
         if (rb_sync[2] == rb_sync[1])
            rb_ready <= rb_sync[1];
      end
   end
   // ==========================================================
   // address packing
   nbc_addr_pack u_pack (
      .x16(x16),
      .col(op_col),
      .page(op_page),
      .plane(op_plane),
      .blk(op_blk),
      .die(op_die),
      .bytes(abytes)
   );
   // ==========================================================
   // request decode
   // only status and reset while busy
   assign refuse = op_kind == 4'd0 && !rb_ready && !nbc_busy_ok(op_cmd);
   assign op_ready = st == NBC_IDLE;
   assign accept = op_valid && op_ready && !refuse;
   assign last = left == 3'd1;
   // write protect held through the latch edge
   assign wp_n = (st != NBC_IDLE || !ce_n) && kind == 4'd0
      ? nbc_modify(cmd) : 1'b1;
   always_comb
   begin
      next_st = st;
      unique case (st)
         NBC_IDLE:
            if (accept)
               next_st = NBC_RUN;
         NBC_RUN:
            next_st = NBC_WAIT;
         NBC_WAIT:
            if (cyc.ack)
               next_st = last ? NBC_IDLE : NBC_RUN;
      endcase
   end
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         st <= NBC_IDLE;
      else
         st <= next_st;
   end
   // ==========================================================
   // operation registers
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         kind <= 4'h0;
         cmd <= 8'h00;
         wdata <= 16'h0000;
         ashift <= 40'h00_0000_0000;
         left <= 3'd0;
      end
      else if (accept)
      begin
         kind <= op_kind;
         cmd <= op_cmd;
         wdata <= op_wdata;
         ashift <= abytes;
         // five cycles, or two for column only
         left <= op_kind == 4'd1 ? 3'(ADDR_CYCLES)
            : op_kind == 4'd4 ? 3'd2 : 3'd1;
      end
      else if (st == NBC_WAIT && cyc.ack)
      begin
         ashift <= {8'h00, ashift[39:8]};
         left <= 3'(left - 3'd1);
      end
   end
   // ==========================================================
   // cycle request
   assign cyc.req = st == NBC_RUN;
   assign cyc.kind = kind == 4'd0 ? NBC_CYC_CMD
      : kind == 4'd2 ? NBC_CYC_WR
      : kind == 4'd3 ? NBC_CYC_RD : NBC_CYC_ADDR;
   // command and address on low byte
   assign cyc.wdata = kind == 4'd0 ? {8'h00, cmd}
      : kind == 4'd2 ? (x16 ? wdata : {8'h00, wdata[7:0]})
      : {8'h00, ashift[7:0]};
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         op_done <= 1'b0;
         op_refused <= 1'b0;
         op_rdata <= 16'h0000;
      end
      else
      begin
         op_done <= st == NBC_WAIT && cyc.ack && last;
         op_refused <= op_valid && op_ready && refuse;
         if (st == NBC_WAIT && cyc.ack && kind == 4'd3)
            op_rdata <= x16 ? cyc.rdata : {8'h00, cyc.rdata[7:0]};
      end
   end
   // ==========================================================
   // pin driver
   nbc_bus_phy #(
      .HOLD(STROBE)
   ) u_phy (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .cyc(cyc.slave),
      .cle(cle),
      .ale(ale),
      .ce_n(ce_n),
      .we_n(we_n),
      .read_strobe_n(read_strobe_n),
      .io_out(io_out),
      .io_oe(io_oe),
      .io_in(io_in)
   );
   // ==========================================================
   // checks
   property p_busy_cmd;
      @(posedge ref_clk) disable iff (!nrst)
      (op_valid && op_ready && op_kind == 4'd0 && !rb_ready
         && !nbc_busy_ok(op_cmd)) |=> op_refused && st == NBC_IDLE;
   endproperty
   a_busy_cmd: assert property (p_busy_cmd)
      else $error("non status command issued while busy");
   property p_cmd_low;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(we_n) && cle |-> io_out[15:8] == 8'h00;
   endproperty
   a_cmd_low: assert property (p_cmd_low)
      else $error("command upper byte not zero");
   property p_cmd_pins;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(we_n) && cle |-> !ale && !ce_n && read_strobe_n;
   endproperty
   a_cmd_pins: assert property (p_cmd_pins)
      else $error("bad pins at command latch");
   property p_addr_pins;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(we_n) && ale |-> !cle && !ce_n && io_out[15:8] == 8'h00;
   endproperty
   a_addr_pins: assert property (p_addr_pins)
      else $error("bad pins at address latch");
   property p_byte2;
      @(posedge ref_clk) disable iff (!nrst)
      (st == NBC_WAIT && kind == 4'd1 && left == 3'd4)
         |-> (x16 ? ashift[7:3] == 5'h0 : ashift[7:4] == 4'h0);
   endproperty
   a_byte2: assert property (p_byte2)
      else $error("second address byte upper bits set");
   property p_wp;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(we_n) && cle && nbc_modify(io_out[7:0]) |-> wp_n;
   endproperty
   a_wp: assert property (p_wp)
      else $error("write protect low on modify command");
   property p_rd_pins;
      @(posedge ref_clk) disable iff (!nrst)
      $fell(read_strobe_n) |-> we_n && !cle && !ale && !ce_n;
   endproperty
   a_rd_pins: assert property (p_rd_pins)
      else $error("bad pins at read strobe");
   property p_wr_data;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(we_n) && !cle && !ale |-> wp_n && io_oe && read_strobe_n;
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("bad pins at data latch");
   sequence s_we_fall_cmd;
      $fell(we_n) && cle;
   endsequence
   sequence s_cmd_ready;
      $past(cle) && !$past(ce_n);
   endsequence
   property p_cmd_setup;
      @(posedge ref_clk) disable iff (!nrst)
      s_we_fall_cmd |-> s_cmd_ready;
   endproperty
   a_cmd_setup: assert property (p_cmd_setup)
      else $error("command latch not set up before strobe");
   property p_wp_addr;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(we_n) && ale |-> wp_n;
   endproperty
   a_wp_addr: assert property (p_wp_addr)
      else $error("write protect low at address latch");
   property p_rd_no_drive;
      @(posedge ref_clk) disable iff (!nrst)
      !read_strobe_n |-> !io_oe;
   endproperty
   a_rd_no_drive: assert property (p_rd_no_drive)
      else $error("host drives lines during read strobe");
   property p_rd_word;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(read_strobe_n) |-> op_done
         && op_rdata == ($past(io_in) & (x16 ? 16'hffff : 16'h00ff));
   endproperty
   a_rd_word: assert property (p_rd_word)
      else $error("read word not taken at strobe end");
   property p_ce_idle;
      @(posedge ref_clk) disable iff (!nrst)
      st == NBC_IDLE && $past(st) == NBC_IDLE |-> ce_n;
   endproperty
   a_ce_idle: assert property (p_ce_idle)
      else $error("chip select low while idle");
   property p_refused_quiet;
      @(posedge ref_clk) disable iff (!nrst)
      op_refused |-> ce_n && st == NBC_IDLE;
   endproperty
   a_refused_quiet: assert property (p_refused_quiet)
      else $error("refused command reached the pins");
endmodule : nbc_host

// [sim/nbc_dev_model.sv]
`timescale 1ns/1ps
module nbc_dev_model
(
   input wire logic cle,
   input wire logic ale,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic read_strobe_n,
   input wire logic wp_n,
   input wire logic [15:0] io_out,
   input wire logic io_oe,
   output logic [15:0] io_in,
   output logic ready_busy_n
);
   logic busy = 1'b0;
   logic drv = 1'b0;
   logic [15:0] word = 16'h0000;
   logic [15:0] col = 16'h0000;
   int ncmd = 0;
   int seen = 0;
   logic [7:0] cmd_q[$];
   logic wp_q[$];
   logic [7:0] adr_q[$];
   logic [15:0] dat_q[$];
   assign ready_busy_n = busy ? 1'b0 : 1'b1;
   // released lines show the inverse of the last word
   assign io_in = (drv && !io_oe) ? word : ~word;
   // ====
   // write strobe capture
   // low lines for command and address on strobe rise, all sixteen lines for data
   always @(posedge we_n)
   begin
      if (ce_n === 1'b0 && read_strobe_n === 1'b1)
      begin
         if (cle === 1'b1 && ale === 1'b0)
         begin
            cmd_q.push_back(io_out[7:0]);
            wp_q.push_back(wp_n);
            ncmd++;
         end
         else if (ale === 1'b1 && cle === 1'b0)
            adr_q.push_back(io_out[7:0]);
         else if (cle === 1'b0 && ale === 1'b0 && wp_n === 1'b1)
            dat_q.push_back(io_out);
      end
   end
   // ====
   // read strobe output
   // each fall gives next word
   always @(negedge read_strobe_n or posedge ce_n)
   begin
      if (ce_n === 1'b1)
         drv = 1'b0;
      else if (we_n === 1'b1 && cle === 1'b0 && ale === 1'b0)
      begin
         if (seen != ncmd)
         begin
            col = 16'h0000;
            seen = ncmd;
         end
         word = 16'ha5c0 + col;
         col = col + 16'h0001;
         drv = 1'b1;
      end
   end
endmodule : nbc_dev_model

// [sim/nbc_host_tb.sv]
`timescale 1ns/1ps
module nbc_host_tb;
   import nbc_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic x16 = 1'b0;
   logic op_valid = 1'b0;
   logic [3:0] op_kind = 4'h0;
   logic [7:0] op_cmd = 8'h00;
   logic [11:0] op_col = 12'h000;
   logic [5:0] op_page = 6'h00;
   logic [11:0] op_blk = 12'h000;
   logic op_plane = 1'b0;
   logic op_die = 1'b0;
   logic [15:0] op_wdata = 16'h0000;
   logic op_ready, op_done, op_refused, cle, ale, ce_n, we_n;
   logic read_strobe_n, wp_n, io_oe, ready_busy_n, refused;
   logic [15:0] op_rdata, io_out, io_in, rd;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   always #25 ref_clk = ~ref_clk;
   nbc_host dut (.ref_clk(ref_clk), .nrst(nrst), .x16(x16), .onfi(1'b0),
      .op_valid(op_valid), .op_ready(op_ready), .op_kind(op_kind),
      .op_cmd(op_cmd), .op_col(op_col), .op_page(op_page), .op_blk(op_blk),
      .op_plane(op_plane), .op_die(op_die), .op_wdata(op_wdata),
      .op_rdata(op_rdata), .op_done(op_done), .op_refused(op_refused),
      .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
      .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out),
      .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));
   nbc_dev_model dev (.cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
      .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out),
      .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));
   // ====
   // shared tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic run_op(input logic [3:0] k, input logic [7:0] c,
      input logic [15:0] wd);
      int n;
      op_kind = k;
      op_cmd = c;
      op_wdata = wd;
      op_valid = 1'b1;
      n = 0;
      while (op_ready !== 1'b1 && n < 100)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n == 100)
         chk(16'h0000, 16'h0001);
      @(posedge ref_clk);
      #1;
      op_valid = 1'b0;
      n = 0;
      while (op_done !== 1'b1 && op_refused !== 1'b1 && n < 200)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      refused = (op_refused === 1'b1);
      rd = op_rdata;
      if (n == 200)
         chk(16'h0000, 16'h0001);
   endtask : run_op
   // ====
   // scenarios
   task automatic t_cmds();
      logic [7:0] codes [24];
      logic m;
      codes = '{CMD_READ, CMD_READ_GO, CMD_READ_CB, CMD_READ_ID, CMD_RESET,
         CMD_PROG, CMD_PLANE_GO, CMD_PROG_P2, CMD_CACHE_GO, CMD_PROG_GO,
         CMD_COPY, CMD_ERASE, CMD_ERASE_P1, CMD_ERASE, CMD_ERASE_GO,
         CMD_STATUS, CMD_STATUS_EN, CMD_STATUS_X2, CMD_STATUS_X3, CMD_RDOUT,
         CMD_RDOUT_GO, CMD_RCACHE, CMD_RCACHE_END, CMD_PARAM};
      for (int j = 0; j < 2; j++)
      begin
         x16 = j[0];
         foreach (codes[i])
         begin
            m = codes[i] inside {8'h80, 8'h81, 8'h85, 8'h60, 8'h10, 8'h15,
               8'h11, 8'hd0, 8'hd1};
            run_op(4'h0, codes[i], 16'hffff);
            chk(16'(dev.cmd_q.size()), 16'h0001);
            chk(16'(dev.cmd_q.pop_front()), 16'(codes[i]));
            chk(16'(dev.wp_q.pop_front()), 16'(m));
         end
      end
   endtask : t_cmds
   task automatic t_addr(input logic w, input logic [3:0] k,
      input logic [11:0] c, input logic [5:0] p, input logic pl,
      input logic [11:0] b, input logic d);
      logic [30:0] a;
      logic [39:0] e;
      int n;
      x16 = w;
      op_col = c;
      op_page = p;
      op_plane = pl;
      op_blk = b;
      op_die = d;
      n = (k == 4'h1) ? 5 : 2;
      run_op(k, 8'h00, 16'h0000);
      if (w)
      begin
         a = {1'b0, d, b | {11'h000, pl}, p, c[10:0]};
         e = {5'h00, a[29:27], a[26:19], a[18:11], 5'h00, a[10:8], a[7:0]};
      end
      else
      begin
         a = {d, b | {11'h000, pl}, p, c};
         e = {5'h00, a[30:28], a[27:20], a[19:12], 4'h0, a[11:8], a[7:0]};
      end
      chk(16'(dev.adr_q.size()), 16'(n));
      for (int i = 0; i < n; i++)
         chk(16'(dev.adr_q.pop_front()), 16'(e[8*i+:8]));
   endtask : t_addr
   task automatic t_data();
      logic [15:0] v;
      x16 = 1'b1;
      run_op(4'h2, 8'h00, 16'hc3a5);
      run_op(4'h2, 8'h00, 16'h5a3c);
      chk(16'(dev.dat_q.size()), 16'h0002);
      chk(dev.dat_q.pop_front(), 16'hc3a5);
      chk(dev.dat_q.pop_front(), 16'h5a3c);
      x16 = 1'b0;
      run_op(4'h2, 8'h00, 16'h965a);
      v = dev.dat_q.pop_front();
      chk({8'h00, v[7:0]}, 16'h005a);
      x16 = 1'b1;
      run_op(4'h0, CMD_READ, 16'h0000);
      dev.cmd_q.delete();
      dev.wp_q.delete();
      run_op(4'h3, 8'h00, 16'h0000);
      chk(rd, 16'ha5c0);
      run_op(4'h3, 8'h00, 16'h0000);
      chk(rd, 16'ha5c1);
   endtask : t_data
   task automatic t_busy();
      logic [7:0] ok [5];
      ok = '{CMD_RESET, CMD_STATUS, CMD_STATUS_EN, CMD_STATUS_X2,
         CMD_STATUS_X3};
      dev.busy = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      run_op(4'h0, CMD_PROG, 16'h0000);
      chk(16'(refused), 16'h0001);
      chk(16'(dev.cmd_q.size()), 16'h0000);
      foreach (ok[i])
      begin
         run_op(4'h0, ok[i], 16'h0000);
         chk(16'(refused), 16'h0000);
         chk(16'(dev.cmd_q.pop_front()), 16'(ok[i]));
      end
      dev.busy = 1'b0;
      dev.wp_q.delete();
      repeat (6) @(posedge ref_clk);
      #1;
   endtask : t_busy
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         close_out();
      end
   end
   initial
   begin
      repeat (4) @(posedge ref_clk);
      chk(16'({ce_n, we_n, read_strobe_n, cle, ale, io_oe, wp_n, op_ready}),
         16'h00e3);
      #1;
      nrst = 1'b1;
      t_cmds();
      t_addr(1'b0, 4'h1, 12'hfff, 6'h3f, 1'b1, 12'hffe, 1'b1);
      t_addr(1'b0, 4'h1, 12'h5a3, 6'h2a, 1'b0, 12'h9b7, 1'b0);
      t_addr(1'b1, 4'h1, 12'hda3, 6'h15, 1'b1, 12'h6c8, 1'b1);
      t_addr(1'b0, 4'h4, 12'h8c1, 6'h00, 1'b0, 12'h000, 1'b0);
      t_addr(1'b1, 4'h4, 12'hf7e, 6'h00, 1'b0, 12'h000, 1'b0);
      t_data();
      t_busy();
      close_out();
   end
endmodule : nbc_host_tb
